// ===== hdl/wsw_params.svh
// Constants for the watchdog, divider and sleep/wake unit
`ifndef WSW_PARAMS_SVH
`define WSW_PARAMS_SVH

`define WSW_DIV_WIDTH      8
`define WSW_CFG_WIDTH      8
`define WSW_PORT_WIDTH     8
`define WSW_CFG_RESET      8'h3F
`define WSW_CFG_IMPL_MASK  8'h3F
`define WSW_ASSIGN_BIT     3
`define WSW_RATIO_MSB      2
`define WSW_RATIO_LSB      0
`define WSW_WDT_PERIOD_NS  18000000
`define WSW_CLK_PERIOD_NS  100

`endif

// ===== hdl/wsw_pkg.sv
// Types shared by the watchdog, sleep and wake unit
`include "wsw_params.svh"

package wsw_pkg;

  typedef enum logic [0:0] {
    WSW_RUN    = 1'b0,
    WSW_ASLEEP = 1'b1
  } wsw_state_e;

  // One-cycle strobes from the core, with the config load data
  typedef struct packed {
    logic                       watchdog_clear_instruction;
    logic                       sleep_instruction;
    logic                       config_load;
    logic [`WSW_CFG_WIDTH-1:0]  config_data;
  } wsw_cmd_s;

  typedef struct packed {
    logic timeout_flag_n;
    logic powerdown_flag_n;
  } wsw_flags_s;

  typedef struct packed {
    logic [`WSW_PORT_WIDTH-1:0] level;
    logic [`WSW_PORT_WIDTH-1:0] drive_en;
  } wsw_pins_s;

endpackage

// ===== hdl/wsw_divider.sv
// Shared event divider with clear and tap mask
`timescale 1ns/10ps
`default_nettype none
`include "wsw_params.svh"

module wsw_divider #(
  parameter int unsigned WIDTH = `WSW_DIV_WIDTH
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_ce,
  input  wire logic             i_clear,
  input  wire logic             i_event,
  input  wire logic [WIDTH-1:0] i_mask,
  output logic                  o_tick,
  output logic [WIDTH-1:0]      o_count
);

  logic [WIDTH-1:0] count_reg;

  // Tick when every bit under the mask is one as an event arrives
  assign o_tick  = i_event && ((count_reg & i_mask) == i_mask);
  assign o_count = count_reg;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      count_reg <= '0;
    else if (i_ce)
    begin
      if (i_clear)
        count_reg <= '0;
      else if (i_event)
        count_reg <= count_reg + WIDTH'(1);
    end
  end

endmodule // wsw_divider

`default_nettype wire

// ===== hdl/wsw_watchdog.sv
// Watchdog timer with shared divider and sleep/wake control
`timescale 1ns/10ps
`default_nettype none
`include "wsw_params.svh"

module wsw_watchdog #(
  parameter int unsigned WDT_BASE_CYCLES =
    `WSW_WDT_PERIOD_NS / `WSW_CLK_PERIOD_NS
) (
  input  wire logic               I_CLK,
  input  wire logic               I_RST_N,
  input  wire logic               I_CE,
  input  wire logic               I_MASTER_CLEAR_PIN_N,
  input  wire logic               I_WATCHDOG_ENABLE_FUSE,
  input  wire wsw_pkg::wsw_cmd_s  I_CMD,
  input  wire logic               I_BASE_TIMER_SRC,
  input  wire wsw_pkg::wsw_pins_s I_PINS,
  output var  wsw_pkg::wsw_pins_s O_PINS,
  output logic                    O_BASE_TIMER_INC,
  output logic                    O_DEVICE_RESET,
  output var  wsw_pkg::wsw_flags_s O_FLAGS,
  output logic                    O_OSC_DRIVER_EN,
  output logic                    O_ASLEEP,
  output logic [`WSW_CFG_WIDTH-1:0] O_CONFIG
);
  import wsw_pkg::*;

  localparam int unsigned CNT_W = $clog2(WDT_BASE_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WDT_BASE_CYCLES - 1);
  localparam int unsigned DW = `WSW_DIV_WIDTH;

  wsw_state_e                state_reg;
  logic                      master_clear_pin_n_meta_reg;
  logic                      master_clear_pin_n_sync_reg;
  logic                      fuse_meta_reg;
  logic                      fuse_sync_reg;
  logic [CNT_W-1:0]          wdt_cnt_reg;
  logic [`WSW_CFG_WIDTH-1:0] config_reg;
  logic                      to_n_reg;
  logic                      pd_n_reg;
  logic                      reset_reg;
  logic                      base_inc_reg;
  wsw_pins_s                 pins_reg;

  logic            master_clear_pin_n_low;
  logic            wdt_enabled;
  logic            wdt_base_evt;
  logic            timeout;
  logic            wipe;
  logic            running;
  logic            clr_accept;
  logic            sleep_accept;
  logic            load_accept;
  logic            to_wdt;
  logic [2:0]      ratio;
  logic [DW-1:0]   wdt_mask;
  logic [DW-1:0]   base_mask;
  logic [DW-1:0]   div_mask;
  logic            div_event;
  logic            div_clear;
  logic            div_tick;

  // Pins from outside the clock domain pass two flip-flops first
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      master_clear_pin_n_meta_reg <= 1'b1;
      master_clear_pin_n_sync_reg <= 1'b1;
      fuse_meta_reg <= 1'b0;
      fuse_sync_reg <= 1'b0;
    end
    else if (I_CE)
    begin
      master_clear_pin_n_meta_reg <= I_MASTER_CLEAR_PIN_N;
      master_clear_pin_n_sync_reg <= master_clear_pin_n_meta_reg;
      fuse_meta_reg <= I_WATCHDOG_ENABLE_FUSE;
      fuse_sync_reg <= fuse_meta_reg;
    end
  end

  assign master_clear_pin_n_low    = !master_clear_pin_n_sync_reg;
  assign wdt_enabled = fuse_sync_reg;
  assign running     = (state_reg == WSW_RUN);
  assign to_wdt      = config_reg[`WSW_ASSIGN_BIT];
  assign ratio       = config_reg[`WSW_RATIO_MSB:`WSW_RATIO_LSB];

  // Core strobes count only while the core runs and is not held in reset
  assign clr_accept   = I_CMD.watchdog_clear_instruction && running
                        && !master_clear_pin_n_low;
  assign sleep_accept = I_CMD.sleep_instruction && running && !wipe;
  assign load_accept  = I_CMD.config_load && running && !wipe;

  // Watchdog ratios 1:1..1:128, base timer ratios 1:2..1:256
  assign wdt_mask  = DW'((9'h001 << ratio) - 9'h001);
  assign base_mask = DW'((9'h002 << ratio) - 9'h001);

  // One divider, owned by exactly one side at a time
  assign div_event = to_wdt ? wdt_base_evt : I_BASE_TIMER_SRC;
  assign div_mask  = to_wdt ? wdt_mask : base_mask;
  // Reassignment also restarts it so a stale count never carries over
  assign div_clear = wipe || load_accept
                     || (to_wdt && (clr_accept || sleep_accept));

  wsw_divider #(
    .WIDTH (DW)
  ) u_divider (
    .i_clk   (I_CLK),
    .i_rst_n (I_RST_N),
    .i_ce    (I_CE),
    .i_clear (div_clear),
    .i_event (div_event),
    .i_mask  (div_mask),
    .o_tick  (div_tick),
    .o_count ()
  );

  // I_CLK stands for the free-running watchdog clock; it is never gated
  // by sleep, only the main oscillator driver output is switched off
  assign wdt_base_evt = wdt_enabled && (wdt_cnt_reg == CNT_LAST);
  assign timeout = wdt_base_evt && (to_wdt ? div_tick : 1'b1);
  assign wipe    = master_clear_pin_n_low || timeout;

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      wdt_cnt_reg <= '0;
    else if (I_CE)
    begin
      if (wipe || clr_accept || sleep_accept)
        wdt_cnt_reg <= '0;
      else if (wdt_enabled)
        wdt_cnt_reg <= (wdt_cnt_reg == CNT_LAST) ? '0
                       : wdt_cnt_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      state_reg <= WSW_RUN;
    else if (I_CE)
    begin
      if (wipe)
        state_reg <= WSW_RUN;
      else if (sleep_accept)
        state_reg <= WSW_ASLEEP;
    end
  end

  // Power-on sets both flags; master clear alone leaves them untouched
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      to_n_reg <= 1'b1;
      pd_n_reg <= 1'b1;
    end
    else if (I_CE)
    begin
      // The timeout wins over a clear in the same cycle
      if (timeout)
        to_n_reg <= 1'b0;
      else if (clr_accept || sleep_accept)
        to_n_reg <= 1'b1;
      if (clr_accept)
        pd_n_reg <= 1'b1;
      else if (sleep_accept)
        pd_n_reg <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      config_reg <= `WSW_CFG_RESET;
    else if (I_CE)
    begin
      if (wipe)
        config_reg <= `WSW_CFG_RESET;
      else if (load_accept)
        config_reg <= I_CMD.config_data & `WSW_CFG_IMPL_MASK;
    end
  end

  // Reset request stays inside the chip; the clear pin is input only
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      reset_reg <= 1'b1;
    else if (I_CE)
      reset_reg <= wipe;
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      base_inc_reg <= 1'b0;
    else if (I_CE)
      base_inc_reg <= to_wdt ? I_BASE_TIMER_SRC : div_tick;
  end

  // Pins freeze while asleep, including their tristate choice
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
      pins_reg <= '0;
    else if (I_CE && running)
      pins_reg <= I_PINS;
  end

  assign O_PINS                   = pins_reg;
  assign O_BASE_TIMER_INC         = base_inc_reg;
  assign O_DEVICE_RESET           = reset_reg;
  assign O_FLAGS                  = '{timeout_flag_n:   to_n_reg,
                                      powerdown_flag_n: pd_n_reg};
  assign O_OSC_DRIVER_EN          = running;
  assign O_ASLEEP                 = !running;
  assign O_CONFIG                 = config_reg;

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  clear_zeroes_a: assert property (
    I_CE && clr_accept && !timeout |=> wdt_cnt_reg == '0)
    else $error("Clear did not zero the watchdog counter");

  sleep_zeroes_a: assert property (
    I_CE && sleep_accept |=> wdt_cnt_reg == '0 && state_reg == WSW_ASLEEP)
    else $error("Sleep did not restart the watchdog");

  // A clear in the same cycle keeps the power-down flag set
  sleep_flags_a: assert property (
    I_CE && sleep_accept && !clr_accept
    |=> to_n_reg && !pd_n_reg && !O_OSC_DRIVER_EN)
    else $error("Sleep entry flags or oscillator wrong");

  pins_hold_a: assert property (
    (state_reg == WSW_ASLEEP) [*2] |-> $stable(O_PINS))
    else $error("Pin state moved during sleep");

  wake_cause_a: assert property (
    I_CE && state_reg == WSW_ASLEEP && !master_clear_pin_n_low && !timeout
    |=> state_reg == WSW_ASLEEP)
    else $error("Left sleep without a wake source");

  timeout_reset_a: assert property (
    I_CE && timeout |=> !to_n_reg && O_DEVICE_RESET && config_reg ==
    `WSW_CFG_RESET)
    else $error("Timeout did not reset and clear the flag");

  wake_clear_a: assert property (
    I_CE && state_reg == WSW_ASLEEP && wipe
    |=> state_reg == WSW_RUN && wdt_cnt_reg == '0)
    else $error("Wake did not clear the watchdog");

  // A disabled watchdog must not even creep towards its end count
  fuse_off_a: assert property (
    !wdt_enabled |-> !timeout
    ##1 (wdt_cnt_reg == '0 || $stable(wdt_cnt_reg)))
    else $error("Disabled watchdog timed out");

  nodiv_period_a: assert property (
    I_CE && !to_wdt && wdt_enabled && wdt_cnt_reg == CNT_LAST |-> timeout)
    else $error("Undivided watchdog period missed");

  clear_flags_a: assert property (
    I_CE && clr_accept && !timeout |=> to_n_reg && pd_n_reg)
    else $error("Clear did not set both flags");

  master_clear_pin_n_reset_a: assert property (
    I_CE && master_clear_pin_n_low |=> O_DEVICE_RESET && config_reg == `WSW_CFG_RESET)
    else $error("Master clear did not reset the config");

  // The base timer sees raw events only while the divider is elsewhere
  base_owner_a: assert property (
    I_CE && to_wdt |=> O_BASE_TIMER_INC == $past(I_BASE_TIMER_SRC))
    else $error("Base timer events lost while divider on watchdog");

  base_prescale_a: assert property (
    I_CE && !to_wdt && !div_tick |=> !O_BASE_TIMER_INC)
    else $error("Base timer stepped without a divider tick");

  reset_internal_a: assert property (
    I_CE && !wipe |=> !O_DEVICE_RESET)
    else $error("Reset request raised without a source");

  sleep_wake_flag_a: assert property (
    I_CE && state_reg == WSW_ASLEEP && timeout
    |=> !to_n_reg && state_reg == WSW_RUN)
    else $error("Timeout wake left the flag or state wrong");

  sleep_wdt_wake_c: cover property (
    state_reg == WSW_ASLEEP && timeout);
  sleep_master_clear_pin_n_wake_c: cover property (
    state_reg == WSW_ASLEEP && master_clear_pin_n_low);
  divided_timeout_c: cover property (
    timeout && to_wdt && ratio == 3'h7);
  clear_then_sleep_c: cover property (
    clr_accept ##[1:20] sleep_accept);
  frozen_asleep_c: cover property (
    !I_CE && state_reg == WSW_ASLEEP);

endmodule // wsw_watchdog

`default_nettype wire

// ===== bench/wsw_core_model.sv
// Behavioural processor core that issues the unit's one-cycle strobes
`timescale 1ns/10ps
`default_nettype none

module wsw_core_model (
  input  wire logic          i_clk,
  output var  wsw_pkg::wsw_cmd_s o_cmd,
  output logic               o_src
);
  import wsw_pkg::*;

  initial
  begin
    o_cmd = '0;
    o_src = 1'b0;
  end

  // Launched just after an edge and held one full cycle, so it is taken once
  task automatic strobe(input wsw_cmd_s c, input logic s);
    @(posedge i_clk);
    #1;
    o_cmd = c;
    o_src = s;
    @(posedge i_clk);
    #1;
    o_cmd = '0;
    o_src = 1'b0;
  endtask

  task automatic do_clear();
    strobe('{1'b1, 1'b0, 1'b0, 8'h00}, 1'b0);
  endtask

  // The core only sleeps while running; it wakes through a reset
  task automatic do_sleep();
    strobe('{1'b0, 1'b1, 1'b0, 8'h00}, 1'b0);
  endtask

  task automatic do_load(input logic [7:0] d);
    strobe('{1'b0, 1'b0, 1'b1, d}, 1'b0);
  endtask

  task automatic do_src();
    strobe('0, 1'b1);
  endtask
endmodule // wsw_core_model

`default_nettype wire

// ===== bench/wsw_watchdog_tb.sv
// Self-checking bench for the watchdog, sleep and wake unit
`timescale 1ns/10ps
`default_nettype none
`include "wsw_params.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, e); end end

module wsw_watchdog_tb;
  import wsw_pkg::*;
  localparam int B = 8;
  logic       clk;
  logic       rst_n;
  logic       ce;
  logic       master_clear_pin_n_n;
  logic       fuse;
  wsw_cmd_s   cmd;
  logic       src;
  wsw_pins_s  pins_i;
  wsw_pins_s  pins_o;
  wsw_flags_s flags;
  logic       inc;
  logic       dev_rst;
  logic       osc_en;
  logic       asleep;
  logic [7:0] cfg;
  int         failures = 0;
  int         n_compared = 0;
  int         n;
  int         n_inc = 0;
  int         n_rst = 0;

  wsw_watchdog #(.WDT_BASE_CYCLES(B)) uut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_MASTER_CLEAR_PIN_N(master_clear_pin_n_n),
    .I_WATCHDOG_ENABLE_FUSE(fuse), .I_CMD(cmd), .I_BASE_TIMER_SRC(src),
    .I_PINS(pins_i), .O_PINS(pins_o), .O_BASE_TIMER_INC(inc),
    .O_DEVICE_RESET(dev_rst), .O_FLAGS(flags), .O_OSC_DRIVER_EN(osc_en),
    .O_ASLEEP(asleep), .O_CONFIG(cfg));

  wsw_core_model core (.i_clk(clk), .o_cmd(cmd), .o_src(src));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (inc === 1'b1) n_inc++;
    if (dev_rst === 1'b1) n_rst++;
  end

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // Counts edges until the reset request shows, giving up after lim + 1 edges
  task automatic wait_rst(input int lim);
    n = 0;
    while (dev_rst !== 1'b1 && n <= lim)
    begin
      tick();
      n++;
    end
    if (n > lim)
    begin
      failures++;
      $display("mismatch t=%0t no reset request", $time);
      tally_and_finish();
    end
  endtask

  task automatic near(input int got, input int e);
    `CHK(got >= e - 1 && got <= e + 1, 1'b1)
  endtask

  // Early clear must be forgotten: the period runs from the second clear
  task automatic run_period(input logic [7:0] c, input int e);
    core.do_load(c);
    `CHK(cfg, c & `WSW_CFG_IMPL_MASK)
    core.do_clear();
    repeat (B - 4) tick();
    core.do_clear();
    wait_rst(e + 4);
    near(n, e);
    `CHK(flags.timeout_flag_n, 1'b0)
    `CHK(cfg, `WSW_CFG_RESET)
    tick();
    `CHK(dev_rst, 1'b0)
    core.do_clear();
    `CHK(flags, 2'b11)
  endtask

  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    master_clear_pin_n_n = 1'b1;
    fuse = 1'b0;
    pins_i = '0;
    repeat (8) @(posedge clk);
    #1;
    `CHK(cfg, `WSW_CFG_RESET)
    `CHK(flags, 2'b11)
    rst_n = 1'b1;
    repeat (3) tick();
    core.do_load(8'h00);
    n_inc = 0;
    n_rst = 0;
    repeat (8) core.do_src();
    tick();
    `CHK(n_inc, 4)
    repeat (100) tick();
    `CHK(n_rst, 0)
    core.do_load(8'h3F);
    fuse = 1'b1;
    repeat (3) tick();
    for (int r = 0; r <= 8; r++)
      run_period(r < 8 ? 8'hC8 | 8'(r) : 8'hC0, r < 8 ? B << r : B);
    core.do_load(8'h08);
    pins_i = '{8'hA5, 8'h0F};
    core.do_clear();
    repeat (3) tick();
    core.do_sleep();
    `CHK(asleep, 1'b1)
    `CHK(osc_en, 1'b0)
    `CHK(flags, 2'b10)
    pins_i = '{8'h5A, 8'hF0};
    tick();
    `CHK(pins_o, 16'hA50F)
    wait_rst(B + 4);
    near(n + 1, B);
    `CHK(flags, 2'b00)
    tick();
    `CHK(asleep, 1'b0)
    wait_rst(1100);
    near(n, 1023);
    tick();
    core.do_clear();
    core.do_sleep();
    `CHK(flags, 2'b10)
    repeat (10) tick();
    master_clear_pin_n_n = 1'b0;
    wait_rst(6);
    tick();
    `CHK(asleep, 1'b0)
    `CHK(flags, 2'b10)
    `CHK(cfg, `WSW_CFG_RESET)
    master_clear_pin_n_n = 1'b1;
    repeat (4) tick();
    `CHK(dev_rst, 1'b0)
    core.do_clear();
    `CHK(flags, 2'b11)
    // With the enable low a load strobe must leave the config alone
    ce = 1'b0;
    core.do_load(8'h05);
    `CHK(cfg, `WSW_CFG_RESET)
    ce = 1'b1;
    core.do_load(8'h05);
    `CHK(cfg, 8'h05)
    tally_and_finish();
  end
endmodule // wsw_watchdog_tb

`default_nettype wire
